// [src/adc_cal_pkg.sv]
// Shared constants and types for the calibration sequencer.
package adc_cal_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] OFFSET_ADDR    = 8'h04;
  localparam logic [7:0] FULLSCALE_ADDR = 8'h08;
  localparam logic [7:0] RESULT_ADDR    = 8'h0c;
  localparam logic [7:0] STATUS_ADDR    = 8'h10;

  // Control register field positions.
  localparam int MODE_LSB    = 0;
  localparam int BIPOLAR_BIT = 3;
  localparam int WORD16_BIT  = 4;
  localparam int GAIN_LSB    = 5;

  // Mode field encodings.
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SELF   = 3'h1;
  localparam logic [2:0] MODE_SYS1   = 3'h2;
  localparam logic [2:0] MODE_SYS2   = 3'h3;
  localparam logic [2:0] MODE_SYSOFF = 3'h4;
  localparam logic [2:0] MODE_BG     = 3'h5;

  // Modulator input selection codes.
  localparam logic [1:0] SEL_ANALOG  = 2'h0;
  localparam logic [1:0] SEL_SHORTED = 2'h1;
  localparam logic [1:0] SEL_REF     = 2'h2;

  // Reset values.
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST   = 24'h400000;  // Unity gain, 2.22 fixed point.

  // Calibration targets and arithmetic.
  localparam logic [23:0] SPAN_UNI  = 24'hffffff;
  localparam logic [23:0] SPAN_BIP  = 24'h7fffff;
  localparam logic [23:0] MIDSCALE  = 24'h800000;
  localparam int          GAIN_FRAC = 22;
  localparam logic [5:0]  DIV_STEPS = 6'h2e;  // 46 quotient bits.

  // Timing: modulator rate is the master clock divided down.
  localparam int         CLK_MHZ     = 200;
  localparam logic [8:0] MOD_DIV     = 9'h100;
  localparam logic [2:0] POINT_OUTS  = 3'h3;  // Filter outputs per calibration point.
  localparam logic [2:0] SETTLE_SELF = 3'h3;  // Resettle outputs after self/offset cal.
  localparam logic [2:0] SETTLE_SYS  = 3'h1;  // Resettle outputs after a system step.
  localparam logic [2:0] BG_POINT    = 3'h1;
  localparam logic [2:0] BG_SETTLE   = 3'h4;

  typedef struct packed {
    logic [2:0] gain;
    logic       word16;
    logic       bipolar;
    logic [2:0] mode;
  } ctrl_t;

  typedef enum {ST_CONVERT, ST_ZERO, ST_FULL, ST_DIVIDE, ST_RESETTLE} seq_state_t;

endpackage

// [src/adc_calibration_sequencer.sv]
// Filter resync and calibration sequencer of a sigma-delta converter, with APB registers.
//
// Function
// - Filter-align falling edge resets filter, known state.
// - Every calibration command resets the filter first.
// - All rates derive from the master clock.
// - Capture zero and full scale, derive slope.
// - 33-bit precision, 16 or 24 bit result.
// - Subtract offset, then multiply by full-scale.
// - Host-written coefficients correct following results.
// - Ready goes low when calibration completes.
// - Ready raised within one modulator cycle.
// - Mode 001 runs self calibration, shorted/reference.
// - Shorted first, reference next, then resettle.
// - Self calibration uses current gain setting.
// - Bipolar uses midscale and positive full scale.
// - Mode 010 converts analog input as zero.
// - Mode 011 converts analog input as full.
// - Repeated first step keeps slope factor.
// - Mode 101 background calibration, rate over six.
// - Mode 100 offset calibration, reference span.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module adc_calibration_sequencer (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        filterAlignN,
  input  wire logic        rawValid,
  input  wire logic [23:0] rawData,
  output logic             modTick,
  output logic             filterReset,
  output logic [1:0]       inputSelect,
  output logic [2:0]       pgaGain,
  output logic             resultReadyN
);

  // Corrected result: offset removed first, then gain applied in 33-bit precision.
  function automatic logic [23:0] correct(input logic [23:0] raw, input logic [23:0] off,
                                          input logic [23:0] gain, input logic bip,
                                          input logic w16);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [32:0] wide;
    logic        [23:0] sat;
    diff = $signed({1'b0, raw}) - $signed({1'b0, off});
    prod = diff * $signed({1'b0, gain});
    wide = 33'(prod >>> adc_cal_pkg::GAIN_FRAC);
    if (bip) begin
      wide = wide + $signed({9'h000, adc_cal_pkg::MIDSCALE});
    end
    if (wide < 0) begin
      sat = 24'h000000;
    end else if (wide > $signed({9'h000, 24'hffffff})) begin
      sat = 24'hffffff;
    end else begin
      sat = wide[23:0];
    end
    correct = w16 ? {8'h00, sat[23:8]} : sat;
  endfunction

  logic             rstMeta;
  logic             rstSync;
  adc_cal_pkg::ctrl_t ctrl_reg, ctrl_next;
  adc_cal_pkg::seq_state_t state_reg, state_next;
  logic [23:0]      offset_reg, offset_next;
  logic [23:0]      gain_reg, gain_next;
  logic [23:0]      result_reg, result_next;
  logic [45:0]      numQ_reg, numQ_next;
  logic [25:0]      rem_reg, rem_next;
  logic [24:0]      den_reg, den_next;
  logic [5:0]       step_reg, step_next;
  logic [2:0]       count_reg, count_next;
  logic [8:0]       div_reg, div_next;
  logic             alignPrev_reg;
  logic             readyN_reg, readyN_next;
  logic             fReset_reg, fReset_next;
  logic [1:0]       sel_reg, sel_next;
  logic             tick_reg, tick_next;
  logic             pready_reg, pready_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic             pslverr_reg, pslverr_next;

  // Reset release through two flops so that every flop leaves reset on one edge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Next-state logic for bus, divider and sequencer.
  always_comb begin
    logic       setup;
    logic       access;
    logic       readResult;
    logic       cmd;
    logic [2:0] newMode;
    logic [2:0] need;
    logic [25:0] trial;
    logic [23:0] span;
    setup        = psel && !penable;
    access       = psel && penable && pready_reg;
    readResult   = access && !pwrite && paddr == adc_cal_pkg::RESULT_ADDR;
    cmd          = 1'b0;
    newMode      = pwdata[adc_cal_pkg::MODE_LSB +: 3];
    need         = 3'h0;
    trial        = 26'h0000000;
    span         = ctrl_reg.bipolar ? adc_cal_pkg::SPAN_BIP : adc_cal_pkg::SPAN_UNI;
    ctrl_next    = ctrl_reg;
    state_next   = state_reg;
    offset_next  = offset_reg;
    gain_next    = gain_reg;
    result_next  = result_reg;
    numQ_next    = numQ_reg;
    rem_next     = rem_reg;
    den_next     = den_reg;
    step_next    = step_reg;
    count_next   = count_reg;
    readyN_next  = readyN_reg;
    fReset_next  = 1'b0;
    sel_next     = sel_reg;
    pready_next  = setup;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;

    // Modulator rate is a fixed division of the master clock.
    div_next  = (div_reg == adc_cal_pkg::MOD_DIV - 9'h001) ? 9'h000 : div_reg + 9'h001;
    tick_next = (div_reg == adc_cal_pkg::MOD_DIV - 9'h001);

    // Register reads are captured in the setup cycle and shown in the access cycle.
    if (setup) begin
      unique case (paddr)
        adc_cal_pkg::CTRL_ADDR:      prdata_next = {24'h000000, ctrl_reg};
        adc_cal_pkg::OFFSET_ADDR:    prdata_next = {8'h00, offset_reg};
        adc_cal_pkg::FULLSCALE_ADDR: prdata_next = {8'h00, gain_reg};
        adc_cal_pkg::RESULT_ADDR:    prdata_next = {8'h00, result_reg};
        adc_cal_pkg::STATUS_ADDR:    prdata_next = {29'h00000000,
                                                    ctrl_reg.mode == adc_cal_pkg::MODE_BG,
                                                    state_reg != adc_cal_pkg::ST_CONVERT,
                                                    readyN_reg};
        default: begin
          prdata_next  = 32'h00000000;
          pslverr_next = 1'b1;
        end
      endcase
    end else begin
      pslverr_next = pslverr_reg && !(psel && penable);
    end

    // Register writes; host coefficients steer later corrections until a calibration overwrites them.
    if (access && pwrite) begin
      unique case (paddr)
        adc_cal_pkg::CTRL_ADDR: begin
          ctrl_next = adc_cal_pkg::ctrl_t'(pwdata[7:0]);
          cmd       = 1'b1;
        end
        adc_cal_pkg::OFFSET_ADDR:    offset_next = pwdata[23:0];
        adc_cal_pkg::FULLSCALE_ADDR: gain_next   = pwdata[23:0];
        default: ;
      endcase
    end

    // Reading the result releases the ready line.
    if (readResult) begin
      readyN_next = 1'b1;
    end

    // A calibration mode write starts calibration with a filter reset; ready rises at once.
    if (cmd) begin
      count_next = 3'h0;
      unique case (newMode)
        adc_cal_pkg::MODE_SELF, adc_cal_pkg::MODE_BG: begin
          state_next  = adc_cal_pkg::ST_ZERO;
          sel_next    = adc_cal_pkg::SEL_SHORTED;
          fReset_next = 1'b1;
          readyN_next = 1'b1;
        end
        adc_cal_pkg::MODE_SYS1, adc_cal_pkg::MODE_SYSOFF: begin
          state_next  = adc_cal_pkg::ST_ZERO;
          sel_next    = adc_cal_pkg::SEL_ANALOG;
          fReset_next = 1'b1;
          readyN_next = 1'b1;
        end
        adc_cal_pkg::MODE_SYS2: begin
          state_next  = adc_cal_pkg::ST_FULL;
          sel_next    = adc_cal_pkg::SEL_ANALOG;
          fReset_next = 1'b1;
          readyN_next = 1'b1;
        end
        default: begin
          state_next = adc_cal_pkg::ST_CONVERT;
          sel_next   = adc_cal_pkg::SEL_ANALOG;
        end
      endcase
    end else if (alignPrev_reg && !filterAlignN) begin
      // Align edge restarts the filter and the current phase count.
      fReset_next = 1'b1;
      count_next  = 3'h0;
      readyN_next = 1'b1;
    end else begin
      unique case (state_reg)
        adc_cal_pkg::ST_CONVERT: begin
          if (rawValid) begin
            result_next = correct(rawData, offset_reg, gain_reg,
                                  ctrl_reg.bipolar, ctrl_reg.word16);
            readyN_next = 1'b0;
          end
        end
        adc_cal_pkg::ST_ZERO: begin
          need = (ctrl_reg.mode == adc_cal_pkg::MODE_BG) ? adc_cal_pkg::BG_POINT
                                                         : adc_cal_pkg::POINT_OUTS;
          if (rawValid) begin
            count_next = count_reg + 3'h1;
            if (count_reg == need - 3'h1) begin
              offset_next = rawData;
              count_next  = 3'h0;
              if (ctrl_reg.mode == adc_cal_pkg::MODE_SYS1) begin
                // Slope factor is left alone on a lone zero step.
                state_next = adc_cal_pkg::ST_RESETTLE;
              end else begin
                state_next = adc_cal_pkg::ST_FULL;
                sel_next   = adc_cal_pkg::SEL_REF;
              end
            end
          end
        end
        adc_cal_pkg::ST_FULL: begin
          need = (ctrl_reg.mode == adc_cal_pkg::MODE_BG) ? adc_cal_pkg::BG_POINT
                                                         : adc_cal_pkg::POINT_OUTS;
          if (rawValid) begin
            count_next = count_reg + 3'h1;
            if (count_reg == need - 3'h1) begin
              // Divisor is the measured span; gain setting is already in it.
              den_next   = {1'b0, rawData} - {1'b0, offset_reg};
              numQ_next  = {span, 22'h000000};
              rem_next   = 26'h0000000;
              step_next  = adc_cal_pkg::DIV_STEPS;
              count_next = 3'h0;
              state_next = adc_cal_pkg::ST_DIVIDE;
            end
          end
        end
        adc_cal_pkg::ST_DIVIDE: begin
          // Restoring division, one quotient bit per clock.
          trial     = {rem_reg[24:0], numQ_reg[45]};
          numQ_next = {numQ_reg[44:0], 1'b0};
          rem_next  = trial;
          if (trial >= {1'b0, den_reg}) begin
            rem_next  = trial - {1'b0, den_reg};
            numQ_next = {numQ_reg[44:0], 1'b1};
          end
          step_next = step_reg - 6'h01;
          if (step_reg == 6'h01) begin
            if (den_reg[24] || den_reg == 25'h0000000 || numQ_next[45:24] != 22'h000000) begin
              gain_next = 24'hffffff;
            end else begin
              gain_next = numQ_next[23:0];
            end
            state_next = adc_cal_pkg::ST_RESETTLE;
            sel_next   = adc_cal_pkg::SEL_ANALOG;
          end
        end
        adc_cal_pkg::ST_RESETTLE: begin
          unique case (ctrl_reg.mode)
            adc_cal_pkg::MODE_BG:                          need = adc_cal_pkg::BG_SETTLE;
            adc_cal_pkg::MODE_SYS1, adc_cal_pkg::MODE_SYS2: need = adc_cal_pkg::SETTLE_SYS;
            default:                                       need = adc_cal_pkg::SETTLE_SELF;
          endcase
          if (rawValid) begin
            count_next = count_reg + 3'h1;
            if (count_reg == need - 3'h1) begin
              count_next  = 3'h0;
              result_next = correct(rawData, offset_reg, gain_reg,
                                    ctrl_reg.bipolar, ctrl_reg.word16);
              readyN_next = 1'b0;
              if (ctrl_reg.mode == adc_cal_pkg::MODE_BG) begin
                // Background mode loops until software changes the mode.
                state_next = adc_cal_pkg::ST_ZERO;
                sel_next   = adc_cal_pkg::SEL_SHORTED;
              end else begin
                ctrl_next.mode = adc_cal_pkg::MODE_NORMAL;
                state_next     = adc_cal_pkg::ST_CONVERT;
              end
            end
          end
        end
      endcase
    end
  end

  // State registers; constant values under reset only.
  always_ff @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      ctrl_reg      <= adc_cal_pkg::ctrl_t'(adc_cal_pkg::CTRL_RST);
      state_reg     <= adc_cal_pkg::ST_CONVERT;
      offset_reg    <= adc_cal_pkg::OFFSET_RST;
      gain_reg      <= adc_cal_pkg::GAIN_RST;
      result_reg    <= 24'h000000;
      numQ_reg      <= 46'h000000000000;
      rem_reg       <= 26'h0000000;
      den_reg       <= 25'h0000000;
      step_reg      <= 6'h00;
      count_reg     <= 3'h0;
      div_reg       <= 9'h000;
      alignPrev_reg <= 1'b1;
      readyN_reg    <= 1'b1;
      fReset_reg    <= 1'b0;
      sel_reg       <= adc_cal_pkg::SEL_ANALOG;
      tick_reg      <= 1'b0;
      pready_reg    <= 1'b0;
      prdata_reg    <= 32'h00000000;
      pslverr_reg   <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      state_reg     <= state_next;
      offset_reg    <= offset_next;
      gain_reg      <= gain_next;
      result_reg    <= result_next;
      numQ_reg      <= numQ_next;
      rem_reg       <= rem_next;
      den_reg       <= den_next;
      step_reg      <= step_next;
      count_reg     <= count_next;
      div_reg       <= div_next;
      alignPrev_reg <= filterAlignN;
      readyN_reg    <= readyN_next;
      fReset_reg    <= fReset_next;
      sel_reg       <= sel_next;
      tick_reg      <= tick_next;
      pready_reg    <= pready_next;
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  // Every output is a flop.
  assign pready       = pready_reg;
  assign prdata       = prdata_reg;
  assign pslverr      = pslverr_reg;
  assign modTick      = tick_reg;
  assign filterReset  = fReset_reg;
  assign inputSelect  = sel_reg;
  assign pgaGain      = ctrl_reg.gain;
  assign resultReadyN = readyN_reg;

endmodule

// [sim/adc_cal_checker.sv]
// Port-level assertions for the calibration sequencer.
`timescale 1ns/1ps
module adc_cal_checker (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        filterAlignN,
  input wire logic        rawValid,
  input wire logic        modTick,
  input wire logic        filterReset,
  input wire logic [1:0]  inputSelect,
  input wire logic [2:0]  pgaGain,
  input wire logic        resultReadyN
);
  logic       ctrlWr;
  logic [8:0] tickCnt_reg;
  logic [8:0] tickCnt_next;
  logic       seen_reg;
  logic       seen_next;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // A completed write to the control word.
  assign ctrlWr = psel && penable && pready && pwrite && paddr == adc_cal_pkg::CTRL_ADDR;

  // Clocks since the last modulator tick; a filter reset may move the phase, so restart.
  always_comb begin
    tickCnt_next = (modTick || filterReset) ? 9'h000 : tickCnt_reg + 9'h001;
    seen_next    = (modTick || filterReset) ? modTick : seen_reg;
  end

  // Registers of the tick counter.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_reg <= 9'h000;
      seen_reg    <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      seen_reg    <= seen_next;
    end
  end

  align_reset_a: assert property ($fell(filterAlignN) |=> filterReset && resultReadyN)
    else $error("align edge did not reset the filter");
  cal_start_a: assert property (ctrlWr && pwdata[2:0] inside {[3'h1:3'h5]} |=> filterReset && resultReadyN)
    else $error("calibration start did not reset filter and raise ready");
  tick_period_a: assert property (modTick && seen_reg |-> tickCnt_reg == 9'h0ff)
    else $error("modulator tick period is not 256 clocks");
  access_wait_a: assert property (psel && !penable |=> pready)
    else $error("access cycle did not answer");
  unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped address answered without error");
  gain_follow_a: assert property (ctrlWr |=> pgaGain == $past(pwdata[7:5]))
    else $error("gain output does not follow control word");
  ready_cause_a: assert property ($fell(resultReadyN) |-> $past(rawValid))
    else $error("ready fell without a filter word");
  self_hold_a: assert property (ctrlWr && pwdata[2:0] == 3'h1 |=> resultReadyN [*8])
    else $error("ready fell early in self calibration");
  self_short_a: assert property (ctrlWr && pwdata[2:0] == 3'h1 |-> ##[1:3] inputSelect == adc_cal_pkg::SEL_SHORTED)
    else $error("self calibration did not select shorted node first");

  bg_cov: cover property (ctrlWr && pwdata[2:0] == 3'h5);
  ready_cov: cover property ($fell(resultReadyN));
  align_cov: cover property ($fell(filterAlignN));
endmodule

bind adc_calibration_sequencer adc_cal_checker adc_cal_checker_i (
  .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .filterAlignN(filterAlignN), .rawValid(rawValid), .modTick(modTick),
  .filterReset(filterReset), .inputSelect(inputSelect), .pgaGain(pgaGain),
  .resultReadyN(resultReadyN));

// [sim/adc_modulator_model.sv]
// Behavioural modulator and decimation filter that feeds raw words to the sequencer.
`timescale 1ns/1ps
module adc_modulator_model #(
  parameter int          PERIOD    = 64,  // Longer than the 46-clock divide, so no word is lost.
  parameter logic [23:0] ZERO_CODE = 24'h000080,
  parameter logic [23:0] REF_CODE  = 24'h800080
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        filterReset,
  input  wire logic [1:0]  inputSelect,
  input  wire logic [23:0] analogLevel,
  output logic             rawValid,
  output logic [23:0]      rawData,
  output int               wordCount
);
  int phase;

  // A filter reset restarts the output period; data is only valid with rawValid.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase     <= 0;
      rawValid  <= 1'b0;
      rawData   <= 24'h000000;
      wordCount <= 0;
    end else begin
      rawValid <= (phase == PERIOD - 1);
      phase    <= (filterReset || phase == PERIOD - 1) ? 0 : phase + 1;
      if (phase == PERIOD - 1) begin
        wordCount <= wordCount + 1;
        if (inputSelect == adc_cal_pkg::SEL_SHORTED) begin
          rawData <= ZERO_CODE;
        end else if (inputSelect == adc_cal_pkg::SEL_REF) begin
          rawData <= REF_CODE;
        end else begin
          rawData <= analogLevel; // Held stable by the bench per step.
        end
      end else begin
        rawData <= ~rawData; // Stale data is scrambled so nobody can rely on it.
      end
    end
  end
endmodule

// [sim/adc_calibration_sequencer_tb.sv]
// Self-checking bench for the calibration sequencer over APB.
`timescale 1ns/1ps
module adc_calibration_sequencer_tb;
  logic        clock, reset_n, psel, penable, pwrite, filterAlignN;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, modTick, filterReset, rawValid, resultReadyN;
  logic [1:0]  inputSelect;
  logic [2:0]  pgaGain;
  logic [23:0] rawData, analogLevel;
  int          wordCount, bad_count, n_compared, snap;

  adc_calibration_sequencer adc_calibration_sequencer_i (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .filterAlignN(filterAlignN), .rawValid(rawValid), .rawData(rawData),
    .modTick(modTick), .filterReset(filterReset), .inputSelect(inputSelect),
    .pgaGain(pgaGain), .resultReadyN(resultReadyN));

  adc_modulator_model adc_modulator_model_i (
    .clock(clock), .reset_n(reset_n), .filterReset(filterReset),
    .inputSelect(inputSelect), .analogLevel(analogLevel), .rawValid(rawValid),
    .rawData(rawData), .wordCount(wordCount));

  // Free-running 200 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  // Waits for a published result and checks how many filter words it took.
  task automatic waitr(input int exp);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (resultReadyN !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      test_done();
    end
    chk(wordCount - snap, exp);
    snap = wordCount;
  endtask

  task automatic conv(input logic [31:0] exp);
    apb(1'b0, adc_cal_pkg::RESULT_ADDR, 32'h0);
    snap = wordCount;
    waitr(1);
    rchk(adc_cal_pkg::RESULT_ADDR, exp);
  endtask

  // Starts a calibration; the ready line is left alone while it settles.
  task automatic cal(input logic [2:0] m, input int words);
    apb(1'b1, adc_cal_pkg::CTRL_ADDR, {29'h0, m});
    snap = wordCount;
    waitr(words);
  endtask

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    filterAlignN = 1'b1;
    analogLevel = 24'h001000;
    bad_count = 0;
    n_compared = 0;
    snap = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (5) @(posedge clock);
    filterAlignN <= 1'b0;
    @(posedge clock);
    filterAlignN <= 1'b1;
    rchk(adc_cal_pkg::CTRL_ADDR, 32'h0);
    rchk(adc_cal_pkg::OFFSET_ADDR, 32'h0);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'h400000);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, adc_cal_pkg::OFFSET_ADDR, 32'h100);
    conv(32'h000f00);
    apb(1'b1, adc_cal_pkg::FULLSCALE_ADDR, 32'h800000);
    conv(32'h001e00);
    apb(1'b1, adc_cal_pkg::CTRL_ADDR, 32'hb0);
    @(posedge clock); // The write edge launches the gain output; look one edge later.
    chk({29'h0, pgaGain}, 32'h5);
    conv(32'h00001e);
    cal(adc_cal_pkg::MODE_SELF, 9);
    rchk(adc_cal_pkg::CTRL_ADDR, 32'h0);
    rchk(adc_cal_pkg::OFFSET_ADDR, 32'h80);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'h7fffff);
    conv(32'h001eff);
    analogLevel <= 24'h000200;
    cal(adc_cal_pkg::MODE_SYS1, 4);
    rchk(adc_cal_pkg::OFFSET_ADDR, 32'h200);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'h7fffff);
    analogLevel <= 24'h600200;
    cal(adc_cal_pkg::MODE_SYS2, 4);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'haaaaaa);
    analogLevel <= 24'h000300;
    cal(adc_cal_pkg::MODE_SYS1, 4);
    rchk(adc_cal_pkg::OFFSET_ADDR, 32'h300);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'haaaaaa);
    analogLevel <= 24'h000080;
    cal(adc_cal_pkg::MODE_SYSOFF, 9);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'h7fffff);
    cal(adc_cal_pkg::MODE_BG, 6);
    apb(1'b0, adc_cal_pkg::RESULT_ADDR, 32'h0);
    snap = wordCount;
    waitr(6);
    rchk(adc_cal_pkg::CTRL_ADDR, 32'h5);
    rchk(adc_cal_pkg::STATUS_ADDR, 32'h6);
    filterAlignN <= 1'b0;
    repeat (3) @(posedge clock);
    chk({31'h0, resultReadyN}, 32'h1);
    filterAlignN <= 1'b1;
    // Bipolar self calibration halves the gain and centres results on midscale.
    analogLevel <= 24'h000100;
    apb(1'b1, adc_cal_pkg::CTRL_ADDR, 32'h09);
    snap = wordCount;
    waitr(9);
    rchk(adc_cal_pkg::FULLSCALE_ADDR, 32'h3fffff);
    rchk(adc_cal_pkg::RESULT_ADDR, 32'h80007f);
    test_done();
  end
endmodule
